//--- hw/gp34_pkg.sv
package gp34_pkg;

  // bus geometry
  localparam int GP34_ADDR_W = 8;
  localparam int GP34_DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] GP34_OFS_P3_PULLUP = 8'h00;
  localparam logic [7:0] GP34_OFS_P3_DIR = 8'h04;
  localparam logic [7:0] GP34_OFS_P4_DIR = 8'h08;
  localparam logic [7:0] GP34_OFS_P4_DATA = 8'h0C;
  localparam logic [7:0] GP34_OFS_P3_PULL_STAT = 8'h10;
  localparam logic [7:0] GP34_OFS_PIN_STAT = 8'h14;

  // reset values
  localparam logic [7:0] GP34_RST_P3_PULLUP = 8'h00;
  localparam logic [7:0] GP34_RST_P3_DIR = 8'h00;
  localparam logic [7:0] GP34_RST_P4_DIR_MODE1 = 8'h40;
  localparam logic [7:0] GP34_RST_P4_DIR_OTHER = 8'h00;
  localparam logic [7:0] GP34_RST_P4_DATA = 8'h00;

  // port 4 bit positions with shared functions
  localparam int GP34_P4_WAIT_BIT = 7;
  localparam int GP34_P4_CLK_BIT = 6;
  localparam int GP34_P4_ASIOS_BIT = 5;
  localparam int GP34_P4_WR_BIT = 4;
  localparam int GP34_P4_RD_BIT = 3;

  // pin status register fields
  localparam int GP34_STAT_EXP_BIT = 0;
  localparam int GP34_STAT_MODE_LSB = 1;
  localparam int GP34_STAT_HWSB_BIT = 3;
  localparam int GP34_STAT_SWSB_BIT = 4;
  localparam int GP34_STAT_P3OE_LSB = 8;
  localparam int GP34_STAT_P4OE_LSB = 16;

  // axi responses
  localparam logic [1:0] GP34_RESP_OKAY = 2'h0;
  localparam logic [1:0] GP34_RESP_SLVERR = 2'h2;

  // operating modes as presented on the mode pins
  typedef enum logic [1:0] {
    GP34_MODE_RSVD = 2'h0,
    GP34_MODE_1 = 2'h1,
    GP34_MODE_2 = 2'h2,
    GP34_MODE_3 = 2'h3
  } gp34_mode_t;

  // port 4 bit 7 function chosen by the wait-mode setting
  typedef enum logic [1:0] {
    GP34_P47_PORT = 2'h0,
    GP34_P47_WAIT = 2'h1,
    GP34_P47_SDA = 2'h2
  } gp34_p47_func_t;

endpackage

//--- hw/gp34_reg_if.sv
`timescale 1ns/1ps
interface gp34_reg_if;
  import gp34_pkg::*;
  logic wr_en;
  logic [GP34_ADDR_W-1:0] wr_addr;
  logic [GP34_DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_en;
  logic [GP34_ADDR_W-1:0] rd_addr;
  logic [GP34_DATA_W-1:0] rd_data;
  logic rd_err;

  // bus side issues accesses, register side decodes them
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_err, rd_data, rd_err);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_err, rd_data, rd_err);
endinterface

//--- hw/gp34_axil_slave.sv
`timescale 1ns/1ps
module gp34_axil_slave
  import gp34_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [GP34_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [GP34_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [GP34_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [GP34_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register access
  gp34_reg_if.bus regs
);

  typedef struct packed {
    logic aw_held;
    logic [GP34_ADDR_W-1:0] awaddr;
    logic w_held;
    logic [GP34_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [GP34_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } gp34_axi_st_t;

  gp34_axi_st_t st_r;
  gp34_axi_st_t st_nxt;

  // ready stays low while a response is pending, so one write and one read at most
  assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_held && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

  // address and data are caught in either order, the write fires once both are held
  always_comb begin
    st_nxt = st_r;
    regs.wr_en = 1'b0;
    regs.wr_addr = st_r.awaddr;
    regs.wr_data = st_r.wdata;
    regs.wr_strb = st_r.wstrb;
    regs.rd_en = 1'b0;
    regs.rd_addr = s_axi_araddr;
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.aw_held && st_r.w_held) begin
      regs.wr_en = 1'b1;
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = regs.wr_err ? GP34_RESP_SLVERR : GP34_RESP_OKAY;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      regs.rd_en = 1'b1;
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = regs.rd_err ? '0 : regs.rd_data;
      st_nxt.rresp = regs.rd_err ? GP34_RESP_SLVERR : GP34_RESP_OKAY;
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // gp34_axil_slave

//--- hw/gp34_p3_cell.sv
`timescale 1ns/1ps
module gp34_p3_cell (
  // mode
  input wire logic expanded,
  input wire logic hw_standby,
  input wire logic in_reset,
  // per-pin control
  input wire logic port3_direction_bit,
  input wire logic port3_pullup_ctrl,
  input wire logic gpio_out,
  // external data bus
  input wire logic bus_out,
  input wire logic bus_drive,
  // pin
  output logic pin_out,
  output logic pin_oe_n,
  output logic pullup_on
);

  // pin function and drive, re-evaluated on any control change
  always_comb begin
    if (hw_standby) begin
      // hardware standby floats the pin
      pin_out = 1'b0;
      pin_oe_n = 1'b1;
    end else if (expanded) begin
      pin_out = bus_out; // data bus line, direction bit ignored
      pin_oe_n = !bus_drive;
    end else begin
      pin_out = gpio_out;
      pin_oe_n = !port3_direction_bit; // 0 input, 1 output
    end
  end

  // pull-up only for a general input with its control bit set
  always_comb begin
    pullup_on = !expanded && !in_reset && !hw_standby && !port3_direction_bit
      && port3_pullup_ctrl;
  end

endmodule // gp34_p3_cell

//--- hw/gp34_top.sv
`timescale 1ns/1ps
module gp34_top
  import gp34_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [GP34_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [GP34_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [GP34_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [GP34_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // operating state
  input wire logic [1:0] op_mode,
  input wire logic external_expansion_enable,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic [1:0] p47_func_sel,
  // port 3 sources
  input wire logic [7:0] port3_gpio_out,
  input wire logic [7:0] data_bus_out,
  input wire logic data_bus_drive,
  output logic [7:0] data_bus_in,
  // port 3 pins
  input wire logic [7:0] p3_pin_in,
  output logic [7:0] p3_pin_out,
  output logic [7:0] p3_pin_oe_n,
  output logic [7:0] p3_pullup_on,
  // port 4 shared functions
  input wire logic system_clock_level,
  input wire logic address_io_strobe_out_n,
  input wire logic write_strobe_out_n,
  input wire logic read_strobe_out_n,
  input wire logic serial_data_drive_low,
  output logic bus_wait_in_n,
  output logic serial_data_pin_zero_in,
  output logic subclock_input,
  // port 4 pins
  input wire logic [7:0] p4_pin_in,
  output logic [7:0] p4_pin_out,
  output logic [7:0] p4_pin_oe_n
);

  typedef struct packed {
    logic [7:0] port3_pullup_ctrl;
    logic [7:0] port3_direction;
    logic [7:0] port4_direction;
    logic [7:0] port4_output_data;
  } gp34_reg_st_t;

  gp34_reg_st_t st_r;
  gp34_reg_st_t st_nxt;
  gp34_reg_st_t st_rst;

  gp34_reg_if regs ();

  gp34_mode_t mode;
  gp34_p47_func_t p47_func;
  logic expanded;
  logic [7:0] port4_read;
  logic [7:0] p3_pull_int;
  logic [7:0] p3_oe_n_int;
  logic [7:0] wr_byte;

  // bus slave
  gp34_axil_slave u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .regs(regs.bus)
  );

  // mode decode; mode 1 has no single-chip form, so it always counts as expanded
  always_comb begin
    mode = gp34_mode_t'(op_mode);
    p47_func = gp34_p47_func_t'(p47_func_sel);
    expanded = (mode == GP34_MODE_1) || external_expansion_enable;
  end

  // reset image; a synchronous reset, so mode and pin 6 may be sampled here
  always_comb begin
    st_rst.port3_pullup_ctrl = GP34_RST_P3_PULLUP;
    st_rst.port3_direction = GP34_RST_P3_DIR;
    if (mode == GP34_MODE_1) begin
      st_rst.port4_direction = GP34_RST_P4_DIR_MODE1;
    end else begin
      st_rst.port4_direction = GP34_RST_P4_DIR_OTHER;
    end
    st_rst.port4_output_data = GP34_RST_P4_DATA;
    st_rst.port4_output_data[GP34_P4_CLK_BIT] = p4_pin_in[GP34_P4_CLK_BIT];
  end

  // port 4 read-back mixes stored data and live pins per direction bit
  always_comb begin
    port4_read = (st_r.port4_direction & st_r.port4_output_data)
      | (~st_r.port4_direction & p4_pin_in);
  end

  // register writes; only byte lane 0 carries register data
  always_comb begin
    st_nxt = st_r;
    wr_byte = regs.wr_data[7:0];
    regs.wr_err = 1'b0;
    if (regs.wr_en) begin
      unique case ({regs.wr_addr[GP34_ADDR_W-1:2], 2'b00})
        GP34_OFS_P3_PULLUP: begin
          if (regs.wr_strb[0]) begin
            st_nxt.port3_pullup_ctrl = wr_byte;
          end
        end
        GP34_OFS_P3_DIR: begin
          if (regs.wr_strb[0]) begin
            st_nxt.port3_direction = wr_byte;
          end
        end
        GP34_OFS_P4_DIR: begin
          if (regs.wr_strb[0]) begin
            st_nxt.port4_direction = wr_byte;
          end
        end
        GP34_OFS_P4_DATA: begin
          if (regs.wr_strb[0]) begin
            st_nxt.port4_output_data = wr_byte;
          end
        end
        GP34_OFS_P3_PULL_STAT, GP34_OFS_PIN_STAT: begin
          // status words ignore writes without error
        end
        default: begin
          regs.wr_err = 1'b1;
        end
      endcase
    end
  end

  // register reads; direction registers are write-only and read as zero
  always_comb begin
    regs.rd_data = '0;
    regs.rd_err = 1'b0;
    unique case ({regs.rd_addr[GP34_ADDR_W-1:2], 2'b00})
      GP34_OFS_P3_PULLUP: begin
        regs.rd_data[7:0] = st_r.port3_pullup_ctrl;
      end
      GP34_OFS_P3_DIR, GP34_OFS_P4_DIR: begin
        regs.rd_data = '0;
      end
      GP34_OFS_P4_DATA: begin
        regs.rd_data[7:0] = port4_read;
      end
      GP34_OFS_P3_PULL_STAT: begin
        regs.rd_data[7:0] = p3_pull_int;
      end
      GP34_OFS_PIN_STAT: begin
        regs.rd_data[GP34_STAT_EXP_BIT] = expanded;
        regs.rd_data[GP34_STAT_MODE_LSB +: 2] = op_mode;
        regs.rd_data[GP34_STAT_HWSB_BIT] = hw_standby;
        regs.rd_data[GP34_STAT_SWSB_BIT] = sw_standby;
        regs.rd_data[GP34_STAT_P3OE_LSB +: 8] = ~p3_oe_n_int;
        regs.rd_data[GP34_STAT_P4OE_LSB +: 8] = ~p4_pin_oe_n;
      end
      default: begin
        regs.rd_err = regs.rd_en;
      end
    endcase
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= st_rst;
    end else begin
      st_r <= st_nxt;
    end
  end

  // port 3: one cell per pin
  for (genvar i = 0; i < 8; i++) begin : g_p3
    gp34_p3_cell u_cell (
      .expanded(expanded),
      .hw_standby(hw_standby),
      .in_reset(!aresetn),
      .port3_direction_bit(st_r.port3_direction[i]),
      .port3_pullup_ctrl(st_r.port3_pullup_ctrl[i]),
      .gpio_out(port3_gpio_out[i]),
      .bus_out(data_bus_out[i]),
      .bus_drive(data_bus_drive),
      .pin_out(p3_pin_out[i]),
      .pin_oe_n(p3_oe_n_int[i]),
      .pullup_on(p3_pull_int[i])
    );
  end

  // port 3 outward views
  assign p3_pin_oe_n = p3_oe_n_int;
  assign p3_pullup_on = p3_pull_int;
  assign data_bus_in = p3_pin_in;

  // port 4 inputs to the shared functions, always visible
  assign bus_wait_in_n = p4_pin_in[GP34_P4_WAIT_BIT];
  assign serial_data_pin_zero_in = p4_pin_in[GP34_P4_WAIT_BIT];
  assign subclock_input = p4_pin_in[GP34_P4_CLK_BIT];

  // port 4 pin functions, purely combinational on mode and direction
  always_comb begin
    p4_pin_out = st_r.port4_output_data;
    p4_pin_oe_n = ~st_r.port4_direction; // general I/O by default
    // bit 6 never drives stored data; when output it carries the clock
    p4_pin_out[GP34_P4_CLK_BIT] = system_clock_level;
    if (expanded) begin
      // strobes own bits 5..3 whatever their direction bits say
      p4_pin_out[GP34_P4_ASIOS_BIT] = address_io_strobe_out_n;
      p4_pin_out[GP34_P4_WR_BIT] = write_strobe_out_n;
      p4_pin_out[GP34_P4_RD_BIT] = read_strobe_out_n;
      p4_pin_oe_n[GP34_P4_ASIOS_BIT] = 1'b0;
      p4_pin_oe_n[GP34_P4_WR_BIT] = 1'b0;
      p4_pin_oe_n[GP34_P4_RD_BIT] = 1'b0;
      unique case (p47_func)
        GP34_P47_WAIT: begin
          // wait is an input only
          p4_pin_out[GP34_P4_WAIT_BIT] = 1'b0;
          p4_pin_oe_n[GP34_P4_WAIT_BIT] = 1'b1;
        end
        GP34_P47_SDA: begin
          // open drain: drive only a low, release for a high
          p4_pin_out[GP34_P4_WAIT_BIT] = 1'b0;
          p4_pin_oe_n[GP34_P4_WAIT_BIT] = !serial_data_drive_low;
        end
        GP34_P47_PORT: begin
          p4_pin_oe_n[GP34_P4_WAIT_BIT] = !st_r.port4_direction[GP34_P4_WAIT_BIT];
        end
        default: begin
          // illegal select: keep the pin an input rather than risk contention
          p4_pin_oe_n[GP34_P4_WAIT_BIT] = 1'b1;
        end
      endcase
    end
    if (hw_standby) begin
      // hardware standby floats every port 4 pin
      p4_pin_oe_n = 8'hFF;
    end
  end

endmodule // gp34_top

//--- tb/gp34_pin_model.sv
`timescale 1ns/1ps
module gp34_pin_model (
  // clock
  input wire logic aclk,
  // design pin drive
  input wire logic [7:0] p3_pin_out,
  input wire logic [7:0] p3_pin_oe_n,
  input wire logic [7:0] p3_pullup_on,
  input wire logic [7:0] p4_pin_out,
  input wire logic [7:0] p4_pin_oe_n,
  // external drivers commanded by the bench
  input wire logic [7:0] ext3_en,
  input wire logic [7:0] ext3_val,
  input wire logic [7:0] ext4_en,
  input wire logic [7:0] ext4_val,
  // resolved pin levels
  output logic [7:0] p3_pin_in,
  output logic [7:0] p4_pin_in
);
  logic [7:0] p3_last_r = 8'h00; // known start, or a floating pin stays unknown forever
  logic [7:0] p4_last_r = 8'h00;

  // design wins, then external drive, then pull-up on port 3 only; a floating pin drifts off its last level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      p3_pin_in[i] = !p3_pin_oe_n[i] ? p3_pin_out[i] : ext3_en[i] ? ext3_val[i] : p3_pullup_on[i] | !p3_last_r[i];
      p4_pin_in[i] = !p4_pin_oe_n[i] ? p4_pin_out[i] : ext4_en[i] ? ext4_val[i] : !p4_last_r[i];
    end
  end

  // last level memory for floating pins
  always_ff @(posedge aclk) begin
    p3_last_r <= p3_pin_in;
    p4_last_r <= p4_pin_in;
  end
endmodule // gp34_pin_model

//--- tb/gp34_top_sva.sv
`timescale 1ns/1ps
module gp34_top_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // mode
  input wire logic [1:0] op_mode,
  input wire logic external_expansion_enable,
  input wire logic hw_standby,
  // port 3
  input wire logic [7:0] data_bus_out,
  input wire logic data_bus_drive,
  input wire logic [7:0] data_bus_in,
  input wire logic [7:0] p3_pin_in,
  input wire logic [7:0] p3_pin_out,
  input wire logic [7:0] p3_pin_oe_n,
  input wire logic [7:0] p3_pullup_on,
  // port 4
  input wire logic system_clock_level,
  input wire logic address_io_strobe_out_n,
  input wire logic write_strobe_out_n,
  input wire logic read_strobe_out_n,
  input wire logic bus_wait_in_n,
  input wire logic subclock_input,
  input wire logic [7:0] p4_pin_in,
  input wire logic [7:0] p4_pin_out,
  input wire logic [7:0] p4_pin_oe_n
);
  logic exp_on;
  logic live;

  // mode 1 counts as expanded whatever the enable says
  assign exp_on = external_expansion_enable || (op_mode == 2'h1);
  assign live = exp_on && !hw_standby;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  pull_off_exp_a: assert property (exp_on |-> p3_pullup_on == 8'h00)
    else $error("port 3 pull-up on while expanded");
  bus_dir_a: assert property (live |-> p3_pin_oe_n == {8{!data_bus_drive}})
    else $error("port 3 drive does not follow data bus");
  bus_data_a: assert property (live && data_bus_drive |-> p3_pin_out == data_bus_out && data_bus_in == p3_pin_in)
    else $error("port 3 data bus value wrong");
  pull_input_a: assert property ((p3_pullup_on & ~p3_pin_oe_n) == 8'h00)
    else $error("pull-up on a driven pin");
  strobe_out_a: assert property (live |-> p4_pin_oe_n[5:3] == 3'h0
    && p4_pin_out[5:3] == {address_io_strobe_out_n, write_strobe_out_n, read_strobe_out_n})
    else $error("bus strobes not on port 4");
  clk_out_a: assert property (!p4_pin_oe_n[6] |-> p4_pin_out[6] == system_clock_level)
    else $error("port 4 bit 6 not the clock");
  in_route_a: assert property (subclock_input == p4_pin_in[6] && bus_wait_in_n == p4_pin_in[7])
    else $error("port 4 input routing wrong");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");

  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (p3_pullup_on != 8'h00);
endmodule // gp34_top_sva

bind gp34_top gp34_top_sva u_gp34_top_sva (.aclk, .aresetn, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_bvalid, .s_axi_bready, .op_mode, .external_expansion_enable, .hw_standby, .data_bus_out,
  .data_bus_drive, .data_bus_in, .p3_pin_in, .p3_pin_out, .p3_pin_oe_n, .p3_pullup_on, .system_clock_level,
  .address_io_strobe_out_n, .write_strobe_out_n, .read_strobe_out_n, .bus_wait_in_n, .subclock_input,
  .p4_pin_in, .p4_pin_out, .p4_pin_oe_n);

//--- tb/gp34_top_tb.sv
`timescale 1ns/1ps
module gp34_top_tb;
  import gp34_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, external_expansion_enable, hw_standby;
  logic sw_standby, data_bus_drive, system_clock_level, address_io_strobe_out_n, write_strobe_out_n;
  logic read_strobe_out_n, serial_data_drive_low, bus_wait_in_n, serial_data_pin_zero_in, subclock_input;
  logic [7:0] s_axi_awaddr, s_axi_araddr, port3_gpio_out, data_bus_out, data_bus_in, p3_pin_in, p3_pin_out;
  logic [7:0] p3_pin_oe_n, p3_pullup_on, p4_pin_in, p4_pin_out, p4_pin_oe_n, ext3_en, ext3_val, ext4_en, ext4_val;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, op_mode, p47_func_sel, rs;
  int bad_count, checked;

  gp34_top u_gp34_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_mode,
    .external_expansion_enable, .hw_standby, .sw_standby, .p47_func_sel, .port3_gpio_out, .data_bus_out,
    .data_bus_drive, .data_bus_in, .p3_pin_in, .p3_pin_out, .p3_pin_oe_n, .p3_pullup_on, .system_clock_level,
    .address_io_strobe_out_n, .write_strobe_out_n, .read_strobe_out_n, .serial_data_drive_low, .bus_wait_in_n,
    .serial_data_pin_zero_in, .subclock_input, .p4_pin_in, .p4_pin_out, .p4_pin_oe_n);

  gp34_pin_model u_gp34_pin_model (.aclk, .p3_pin_out, .p3_pin_oe_n, .p3_pullup_on, .p4_pin_out, .p4_pin_oe_n,
    .ext3_en, .ext3_val, .ext4_en, .ext4_val, .p3_pin_in, .p4_pin_in);

  // 50 ns period
  initial begin
    aclk = 1'h0;
    forever #25 aclk = ~aclk;
  end

  task automatic close_out;
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // handshake levels are sampled at the falling edge, the value the next rising edge will see
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) break;
    end
    s_axi_bready <= 1'h0;
    if (n == 40) begin
      bad_count++;
      close_out();
    end
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) break;
    end
    s_axi_rready <= 1'h0;
    if (n == 40) begin
      bad_count++;
      close_out();
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    axr(a, rd, rs);
    chk("rdata", e, rd);
  endtask

  task automatic rst(input logic [1:0] m);
    @(posedge aclk);
    aresetn <= 1'h0;
    op_mode <= m;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
  endtask

  task automatic t_reset;
    rst(2'h2);
    @(negedge aclk);
    chk("p4_oe_n", 32'h0FF, 32'(p4_pin_oe_n));
    rdchk(GP34_OFS_P3_PULLUP, 32'h0);
    rdchk(GP34_OFS_P4_DIR, 32'h0);
    rdchk(GP34_OFS_PIN_STAT, 32'h4);
    axr(8'h20, rd, rs);
    chk("rresp", 32'(GP34_RESP_SLVERR), 32'(rs));
    axw(8'h20, 32'h0FF, rs);
    chk("bresp", 32'(GP34_RESP_SLVERR), 32'(rs));
    // pin 6 sat low through reset while the data register is read through its set direction bit
    axw(GP34_OFS_P4_DIR, 32'h40, rs);
    rdchk(GP34_OFS_P4_DATA, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_mode1;
    ext4_val <= 8'h40;
    system_clock_level <= 1'h1;
    rst(2'h1);
    @(negedge aclk);
    chk("p4_oe_n", 32'h87, 32'(p4_pin_oe_n));
    chk("p46_out", 32'h1, 32'(p4_pin_out[6]));
    rdchk(GP34_OFS_P4_DATA, 32'h78);
    axw(GP34_OFS_P4_DIR, 32'h0FF, rs);
    rdchk(GP34_OFS_P4_DATA, 32'h40);
    $display("mode 1 test done");
  endtask

  task automatic t_pullup;
    rst(2'h2);
    axw(GP34_OFS_P3_PULLUP, 32'h0A5, rs);
    rdchk(GP34_OFS_P3_PULLUP, 32'h0A5);
    port3_gpio_out <= 8'h3C;
    axw(GP34_OFS_P3_DIR, 32'h0F, rs);
    @(negedge aclk);
    chk("p3_oe_n", 32'h0F0, 32'(p3_pin_oe_n));
    chk("p3_out", 32'h0C, 32'(p3_pin_out & 8'h0F));
    chk("p3_pull", 32'h0A0, 32'(p3_pullup_on));
    chk("p3_level", 32'h0AC, 32'(data_bus_in & 8'h0AF));
    rdchk(GP34_OFS_P3_PULL_STAT, 32'h0A0);
    @(posedge aclk);
    external_expansion_enable <= 1'h1;
    data_bus_drive <= 1'h1;
    data_bus_out <= 8'h5A;
    @(negedge aclk);
    chk("p3_pull", 32'h0, 32'(p3_pullup_on));
    chk("p3_out", 32'h5A, 32'(p3_pin_out));
    @(posedge aclk);
    hw_standby <= 1'h1;
    @(negedge aclk);
    chk("p3_oe_n", 32'h0FF, 32'(p3_pin_oe_n));
    chk("p3_pull", 32'h0, 32'(p3_pullup_on));
    @(posedge aclk);
    hw_standby <= 1'h0;
    external_expansion_enable <= 1'h0;
    data_bus_drive <= 1'h0;
    $display("pull-up test done");
  endtask

  task automatic t_port4;
    logic [1:0] sel [3] = '{2'h1, 2'h2, 2'h2};
    logic [0:2] low = 3'h2;
    logic [0:2] oe = 3'h5;
    ext4_val <= 8'hC3;
    system_clock_level <= 1'h0;
    rst(2'h3);
    axw(GP34_OFS_P4_DATA, 32'h0FF, rs);
    axw(GP34_OFS_P4_DIR, 32'h55, rs);
    @(negedge aclk);
    chk("p4_oe_n", 32'h0AA, 32'(p4_pin_oe_n));
    chk("p4_out", 32'h15, 32'(p4_pin_out & 8'h55));
    rdchk(GP34_OFS_P4_DATA, 32'h0D7);
    external_expansion_enable <= 1'h1;
    write_strobe_out_n <= 1'h0;
    axw(GP34_OFS_P4_DIR, 32'h87, rs);
    @(negedge aclk);
    chk("p4_oe_n", 32'h40, 32'(p4_pin_oe_n));
    chk("strobes", 32'h5, 32'(p4_pin_out[5:3]));
    // wait input, then open-drain serial data pulled low and released
    for (int i = 0; i < 3; i++) begin
      @(posedge aclk);
      p47_func_sel <= sel[i];
      serial_data_drive_low <= low[i];
      @(negedge aclk);
      chk("p47_oe_n", 32'(oe[i]), 32'(p4_pin_oe_n[7]));
      chk("sda_in", 32'(oe[i]), 32'(serial_data_pin_zero_in));
    end
    $display("port 4 test done");
  endtask

  initial begin
    aresetn = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    op_mode = 2'h2;
    {external_expansion_enable, hw_standby, sw_standby, data_bus_drive, serial_data_drive_low} = 5'h0;
    {system_clock_level, address_io_strobe_out_n, write_strobe_out_n, read_strobe_out_n} = 4'hF;
    {port3_gpio_out, data_bus_out, ext3_en, ext3_val, ext4_val} = 40'h0;
    ext4_en = 8'hFF;
    p47_func_sel = 2'h0;
    bad_count = 0;
    checked = 0;
    t_reset();
    t_mode1();
    t_pullup();
    t_port4();
    close_out();
  end
endmodule // gp34_top_tb
